// >>> hdl/t1ec_sat_counter.sv
/*
   t1ec_sat_counter: running saturating count that is moved to a readable
   copy on every one-second boundary.
   assumes: inc and tick are one-cycle pulses synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none

module t1ec_sat_counter #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input  wire logic   clk,
   input  wire logic   rst_b,
   // events in, latched count out
   t1ec_cnt_if.counter cnt
);

   localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};
   localparam logic [WIDTH-1:0] ONE      = {{(WIDTH-1){1'b0}}, 1'b1};
   localparam logic [WIDTH-1:0] ZERO     = {WIDTH{1'b0}};

   logic [WIDTH-1:0] running;
   logic [WIDTH-1:0] latched;
   logic [WIDTH-1:0] next_running;
   logic [WIDTH-1:0] next_latched;

   // an event in the boundary cycle belongs to the new second, never lost
   always_comb
   begin
      next_running = running;
      next_latched = latched;
      if (cnt.tick)
      begin
         next_latched = running;                  // [R3]
         next_running = cnt.inc ? ONE : ZERO;
      end
      else if (cnt.inc && running != ALL_ONES)    // [R4]
      begin
         next_running = running + ONE;
      end
   end

   // state registers
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         running <= ZERO;
         latched <= ZERO;
      end
      else
      begin
         running <= next_running;
         latched <= next_latched;
      end
   end

   assign cnt.value = latched;

endmodule

`default_nettype wire

// >>> hdl/t1ec_top.sv
/*
   t1ec_top: receive error counters latched once a second and the two
   interrupt mask registers, reached over a byte-wide parallel port.
   assumes: all inputs synchronous to clk; event inputs are one-cycle
   pulses from the receive framer and line decoder; status flags come
   from the status registers held elsewhere.
*/
// Summary of operation
// [R1] first mask: bit per first-status flag, 1 enables, loop-up at bit 7.
// [R2] second mask: bits 7..1 gate second-status flags; bit 0 unassigned.
// [R3] all three counts move to readable copies at each one-second boundary.
// [R4] counters stop at their maximum and never wrap.
// [R5] host reads every counter within one second after the tick.
// [R6] line violation count is 16 bits, high byte 0x23, low 0x24.
// [R7] count bipolar violations, plus zero runs when selected; skip B8ZS words.
// [R8] line violation counter runs even while sync is lost.
// [R9] path counter: CRC6 errors in ESF; Ft, optionally Fs, errors in D4.
// [R10] path counter halts while receive sync is lost.
// [R11] path bits 11..8 in low nibble of 0x25, bits 7..0 at 0x26.
// [R12] mode bit set: count out-of-sync multiframes, also during sync loss.
// [R13] mode bit clear: count Ft or FPS errors, halted during sync loss.
// [R14] out-of-sync count 12 bits: 11..8 upper nibble 0x25, 7..0 at 0x27.
// [R15] interrupt low while any flag is set with its mask bit at 1.
`timescale 1ns/100ps
`default_nettype none

module t1ec_top #(
   parameter int LINE_W = t1ec_pkg::LINE_CNT_W,
   parameter int PATH_W = t1ec_pkg::PATH_CNT_W,
   parameter int SYNC_W = t1ec_pkg::SYNC_CNT_W
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // parallel control port
   input  wire logic [7:0] addr,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] rd_data,
   // configuration bits
   input  wire logic       count_excess_zeros_sel,
   input  wire logic       zero_substitution_enable,
   input  wire logic       framing_format_sel,
   input  wire logic       count_fs_errors_sel,
   input  wire logic       sync_count_mode_sel,
   // receive events
   input  wire logic       one_second_tick,
   input  wire logic       rx_sync_lost,
   input  wire logic       bipolar_violation,
   input  wire logic       b8zs_codeword,
   input  wire logic       zeros16_run,
   input  wire logic       zeros8_run,
   input  wire logic       crc6_error,
   input  wire logic       ft_error,
   input  wire logic       fs_error,
   input  wire logic       fps_error,
   input  wire logic       multiframe_out_of_sync,
   // status flags and interrupt
   input  wire logic [7:0] status_first,
   input  wire logic [7:0] status_second,
   output logic            int_b
);

   // counter links
   t1ec_cnt_if #(.WIDTH(LINE_W)) line_link ();
   t1ec_cnt_if #(.WIDTH(PATH_W)) path_link ();
   t1ec_cnt_if #(.WIDTH(SYNC_W)) sync_link ();

   logic [7:0] interrupt_mask_first;
   logic [7:0] interrupt_mask_second;
   logic [7:0] next_mask_first;
   logic [7:0] next_mask_second;
   logic [7:0] next_rd_data;
   logic       line_event;
   logic       path_event;
   logic       sync_event;
   logic       rd_data_en;
   logic [7:0] int_active;

   // line code violations: a B8ZS codeword carries intended violations,
   // so with substitution on its bipolar violations are dropped; several
   // kinds in one cycle count once since they describe one line event
   always_comb
   begin
      line_event = bipolar_violation
                   && !(zero_substitution_enable && b8zs_codeword);  // [R7]
      if (count_excess_zeros_sel)
      begin
         if (zero_substitution_enable)
         begin
            line_event = line_event || zeros8_run;                 // [R7]
         end
         else
         begin
            line_event = line_event || zeros16_run;                // [R7]
         end
      end
   end

   // path violations, gated off during loss of sync
   always_comb
   begin
      if (framing_format_sel)
      begin
         path_event = crc6_error;                                    // [R9]
      end
      else
      begin
         path_event = ft_error || (count_fs_errors_sel && fs_error); // [R9]
      end
      if (rx_sync_lost)
      begin
         path_event = 1'b0;                                          // [R10]
      end
   end

   // out-of-sync multiframes or framing pattern errors
   always_comb
   begin
      if (sync_count_mode_sel)
      begin
         sync_event = multiframe_out_of_sync;                        // [R12]
      end
      else if (rx_sync_lost)
      begin
         sync_event = 1'b0;                                          // [R13]
      end
      else
      begin
         sync_event = framing_format_sel ? fps_error : ft_error;     // [R13]
      end
   end

   // the line counter is never gated by sync loss
   assign line_link.inc  = line_event;                               // [R8]
   assign path_link.inc  = path_event;
   assign sync_link.inc  = sync_event;
   assign line_link.tick = one_second_tick;                          // [R3]
   assign path_link.tick = one_second_tick;                          // [R3]
   assign sync_link.tick = one_second_tick;                          // [R3]

   // one saturating counter per error class
   t1ec_sat_counter #(.WIDTH(LINE_W)) u_line_cnt (
      .clk   (clk),
      .rst_b (rst_b),
      .cnt   (line_link.counter)
   );

   t1ec_sat_counter #(.WIDTH(PATH_W)) u_path_cnt (
      .clk   (clk),
      .rst_b (rst_b),
      .cnt   (path_link.counter)
   );

   t1ec_sat_counter #(.WIDTH(SYNC_W)) u_sync_cnt (
      .clk   (clk),
      .rst_b (rst_b),
      .cnt   (sync_link.counter)
   );

   // mask register writes; unassigned bit 0 of the second mask is kept
   // at zero so a careless write cannot leave a phantom enable
   always_comb
   begin
      next_mask_first  = interrupt_mask_first;
      next_mask_second = interrupt_mask_second;
      if (wr_en && addr == t1ec_pkg::OFS_MASK_FIRST)
      begin
         next_mask_first = wr_data;                                  // [R1]
      end
      if (wr_en && addr == t1ec_pkg::OFS_MASK_SECOND)
      begin
         next_mask_second = wr_data & t1ec_pkg::SECOND_WR_MASK;      // [R2]
      end
   end

   // read mux; unmapped addresses return zero; the host must fetch all
   // bytes before the next tick since reads are not snapshotted
   always_comb
   begin
      rd_data_en   = rd_en;
      next_rd_data = rd_data;
      if (rd_data_en)
      begin
         unique case (addr)
            t1ec_pkg::OFS_LINE_HIGH:
               next_rd_data = line_link.value[15:8];                 // [R6]
            t1ec_pkg::OFS_LINE_LOW:
               next_rd_data = line_link.value[7:0];                  // [R6]
            t1ec_pkg::OFS_PATH_SYNC_H:
               next_rd_data = {sync_link.value[11:8],
                               path_link.value[11:8]};               // [R11] [R14]
            t1ec_pkg::OFS_PATH_LOW:
               next_rd_data = path_link.value[7:0];                  // [R11]
            t1ec_pkg::OFS_SYNC_LOW:
               next_rd_data = sync_link.value[7:0];                  // [R14]
            t1ec_pkg::OFS_MASK_FIRST:
               next_rd_data = interrupt_mask_first;
            t1ec_pkg::OFS_MASK_SECOND:
               next_rd_data = interrupt_mask_second;
            default:
               next_rd_data = t1ec_pkg::READ_RESET;
         endcase
      end
   end

   // register state
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         interrupt_mask_first  <= t1ec_pkg::MASK_RESET;
         interrupt_mask_second <= t1ec_pkg::MASK_RESET;
         rd_data               <= t1ec_pkg::READ_RESET;
      end
      else
      begin
         interrupt_mask_first  <= next_mask_first;
         interrupt_mask_second <= next_mask_second;
         rd_data               <= next_rd_data;
      end
   end

   // interrupt: combinational from flags so it follows them with no lag
   assign int_active = (status_first & interrupt_mask_first)
                       | (status_second & interrupt_mask_second);    // [R15]
   assign int_b      = ~|int_active;                                 // [R15]

endmodule

`default_nettype wire

// >>> include/t1ec_cnt_if.sv
/*
   t1ec_cnt_if: link between the top block and one saturating counter.
   assumes: one owner drives inc and tick, the counter drives value.
*/
`timescale 1ns/100ps
`default_nettype none

interface t1ec_cnt_if #(parameter int WIDTH = 16);
   logic             inc;   // one event this cycle
   logic             tick;  // one-second boundary
   logic [WIDTH-1:0] value; // count of the previous second

   modport owner   (output inc, output tick, input value);
   modport counter (input inc, input tick, output value);
endinterface

`default_nettype wire

// >>> include/t1ec_pkg.sv
/*
   t1ec_pkg: register offsets, field positions, widths and reset values
   for the receive error counters and the two interrupt mask registers.
   assumes: every user writes package::name, nothing is imported.
*/
`default_nettype none

package t1ec_pkg;

   // register byte offsets on the parallel control port
   localparam logic [7:0] OFS_LINE_HIGH   = 8'h23;
   localparam logic [7:0] OFS_LINE_LOW    = 8'h24;
   localparam logic [7:0] OFS_PATH_SYNC_H = 8'h25;
   localparam logic [7:0] OFS_PATH_LOW    = 8'h26;
   localparam logic [7:0] OFS_SYNC_LOW    = 8'h27;
   localparam logic [7:0] OFS_MASK_SECOND = 8'h6F;
   localparam logic [7:0] OFS_MASK_FIRST  = 8'h6E;

   // counter widths
   localparam int LINE_CNT_W = 16;
   localparam int PATH_CNT_W = 12;
   localparam int SYNC_CNT_W = 12;

   // first mask register bit positions
   localparam int MF_LOOP_UP     = 7;
   localparam int MF_LOOP_DOWN   = 6;
   localparam int MF_TX_CLK_LOST = 5;
   localparam int MF_SLIP        = 4;
   localparam int MF_BLUE        = 3;
   localparam int MF_YELLOW      = 2;
   localparam int MF_CARRIER     = 1;
   localparam int MF_SYNC_LOST   = 0;

   // second mask register bit positions; bit 0 is unassigned
   localparam int MS_RX_MF       = 7;
   localparam int MS_TX_MF       = 6;
   localparam int MS_SECOND      = 5;
   localparam int MS_RX_FULL     = 4;
   localparam int MS_TX_EMPTY    = 3;
   localparam int MS_RX_MATCH    = 2;
   localparam int MS_RX_ABORT    = 1;
   localparam int MS_UNASSIGNED  = 0;

   // values after reset, and the write mask for the second mask register
   localparam logic [7:0] MASK_RESET      = 8'h00;
   localparam logic [7:0] READ_RESET      = 8'h00;
   localparam logic [7:0] SECOND_WR_MASK  = 8'hFE;

endpackage

`default_nettype wire

// >>> tb/t1ec_asserts.sv
/*
   t1ec_asserts: port checker for t1ec_top, bound at the foot.
   assumes: sees only top ports; masks and counts are shadowed here.
*/
`timescale 1ns/100ps
`default_nettype none
module t1ec_asserts #(
   parameter int LINE_W = 16,
   parameter int PATH_W = 12,
   parameter int SYNC_W = 12
) (
   // clock and port
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic [7:0] addr,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   // configuration and events
   input wire logic       count_excess_zeros_sel,
   input wire logic       zero_substitution_enable,
   input wire logic       framing_format_sel,
   input wire logic       count_fs_errors_sel,
   input wire logic       sync_count_mode_sel,
   input wire logic       one_second_tick,
   input wire logic       rx_sync_lost,
   input wire logic       bipolar_violation,
   input wire logic       b8zs_codeword,
   input wire logic       zeros16_run,
   input wire logic       zeros8_run,
   input wire logic       crc6_error,
   input wire logic       ft_error,
   input wire logic       fs_error,
   input wire logic       fps_error,
   input wire logic       multiframe_out_of_sync,
   // flags
   input wire logic [7:0] status_first,
   input wire logic [7:0] status_second,
   input wire logic       int_b
);
   logic [7:0]        mf, ms;
   logic [LINE_W-1:0] lr, ll;
   logic [PATH_W-1:0] pr, pl;
   logic [SYNC_W-1:0] sr, sl;
   // qualified events; simultaneous line kinds count once
   wire logic le = bipolar_violation && !(zero_substitution_enable && b8zs_codeword)
      || count_excess_zeros_sel && (zero_substitution_enable ? zeros8_run : zeros16_run);
   wire logic pe = !rx_sync_lost && (framing_format_sel ? crc6_error
      : ft_error || count_fs_errors_sel && fs_error);
   wire logic se = sync_count_mode_sel ? multiframe_out_of_sync
      : !rx_sync_lost && (framing_format_sel ? fps_error : ft_error);
   // shadow state: all-ones guard keeps the running counts from wrapping
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         {mf, ms, lr, ll, pr, pl, sr, sl} <= '0;
      else
      begin
         if (wr_en && addr == t1ec_pkg::OFS_MASK_FIRST) mf <= wr_data;
         if (wr_en && addr == t1ec_pkg::OFS_MASK_SECOND) ms <= wr_data & 8'hFE;
         lr <= one_second_tick ? LINE_W'(le) : lr + LINE_W'(le && !(&lr));
         pr <= one_second_tick ? PATH_W'(pe) : pr + PATH_W'(pe && !(&pr));
         sr <= one_second_tick ? SYNC_W'(se) : sr + SYNC_W'(se && !(&sr));
         if (one_second_tick) {ll, pl, sl} <= {lr, pr, sr};
      end
   end
   int_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      int_b == !(|(status_first & mf) || |(status_second & ms))) else $error("int_b level");
   mask_first_a: assert property (@(posedge clk) disable iff (!rst_b)
      rd_en && !wr_en && addr == 8'h6E |=> rd_data == $past(mf)) else $error("first mask");
   mask_second_a: assert property (@(posedge clk) disable iff (!rst_b)
      rd_en && !wr_en && addr == 8'h6F |=> rd_data == $past(ms)) else $error("second mask");
   line_high_a: assert property (@(posedge clk) disable iff (!rst_b)
      rd_en && !one_second_tick && addr == 8'h23 |=> rd_data == $past(ll[15:8]))
      else $error("line high byte");
   line_low_a: assert property (@(posedge clk) disable iff (!rst_b)
      rd_en && !one_second_tick && addr == 8'h24 |=> rd_data == $past(ll[7:0]))
      else $error("line low byte");
   shared_high_a: assert property (@(posedge clk) disable iff (!rst_b)
      rd_en && !one_second_tick && addr == 8'h25 |=> rd_data == $past({sl[11:8], pl[11:8]}))
      else $error("shared high byte");
   path_low_a: assert property (@(posedge clk) disable iff (!rst_b)
      rd_en && !one_second_tick && addr == 8'h26 |=> rd_data == $past(pl[7:0]))
      else $error("path low byte");
   sync_low_a: assert property (@(posedge clk) disable iff (!rst_b)
      rd_en && !one_second_tick && addr == 8'h27 |=> rd_data == $past(sl[7:0]))
      else $error("sync low byte");
   unmapped_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      rd_en && addr > 8'h27 && addr < 8'h6E |=> rd_data == 8'h00) else $error("unmapped read");
   rd_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      !rd_en |=> $stable(rd_data)) else $error("rd_data moved");
endmodule
bind t1ec_top t1ec_asserts #(.LINE_W(LINE_W), .PATH_W(PATH_W), .SYNC_W(SYNC_W)) chk (.*);
`default_nettype wire

// >>> tb/t1ec_host.sv
/*
   t1ec_host: host controller on the parallel port, as byte tasks.
   assumes: one task at a time, called from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module t1ec_host (
   // clock
   input  wire logic       clk,
   // parallel port
   output logic      [7:0] addr,
   output logic            wr_en,
   output logic            rd_en,
   output logic      [7:0] wr_data,
   input  wire logic [7:0] rd_data
);
   // idle port from time zero
   initial
   begin
      addr = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      wr_data = 8'h00;
   end
   // address and data held through the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // caller must read counters inside the second after the tick
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(posedge clk);
      d = rd_data;
   endtask
endmodule
`default_nettype wire

// >>> tb/t1ec_top_tb.sv
/*
   t1ec_top_tb: register, mask and counter tests of t1ec_top.
   assumes: host model drives the port; bench drives events and flags.
*/
`timescale 1ns/100ps
`default_nettype none
module t1ec_top_tb;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        tick = 1'b0;
   logic        lost = 1'b0;
   logic        wr_en, rd_en, int_b;
   logic [7:0]  addr, wr_data, rd_data, v;
   logic [7:0]  stf = 8'h00;
   logic [7:0]  sts = 8'h00;
   logic [4:0]  cfg = 5'h00;
   logic [8:0]  ev = 9'h000;
   logic [7:0]  ad[8] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h6E, 8'h6F, 8'h30};
   logic [17:0] cs[15] = '{{5'b00000,1'b0,9'h100,3'b100}, {5'b00000,1'b0,9'h140,3'b100},
      {5'b00000,1'b0,9'h040,3'b000}, {5'b10000,1'b0,9'h040,3'b100},
      {5'b11000,1'b0,9'h040,3'b000}, {5'b11000,1'b0,9'h020,3'b100},
      {5'b01000,1'b0,9'h180,3'b000}, {5'b00100,1'b0,9'h010,3'b010},
      {5'b00100,1'b0,9'h002,3'b001}, {5'b00000,1'b0,9'h008,3'b011},
      {5'b00010,1'b0,9'h004,3'b010}, {5'b00000,1'b0,9'h004,3'b000},
      {5'b00001,1'b0,9'h009,3'b011}, {5'b00001,1'b1,9'h119,3'b101},
      {5'b00100,1'b1,9'h112,3'b100}};
   int          err_count = 0;
   int          n_checks = 0;
   int          cyc = 0;
   t1ec_host host (.clk(clk), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
      .wr_data(wr_data), .rd_data(rd_data));
   t1ec_top uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
      .wr_data(wr_data), .rd_data(rd_data), .count_excess_zeros_sel(cfg[4]),
      .zero_substitution_enable(cfg[3]), .framing_format_sel(cfg[2]),
      .count_fs_errors_sel(cfg[1]), .sync_count_mode_sel(cfg[0]),
      .one_second_tick(tick), .rx_sync_lost(lost), .bipolar_violation(ev[8]),
      .b8zs_codeword(ev[7]), .zeros16_run(ev[6]), .zeros8_run(ev[5]), .crc6_error(ev[4]),
      .ft_error(ev[3]), .fs_error(ev[2]), .fps_error(ev[1]), .multiframe_out_of_sync(ev[0]),
      .status_first(stf), .status_second(sts), .int_b(int_b));
   // 40 MHz clock
   always #12.5 clk = ~clk;
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one pulse per cycle, back to back
   task automatic fire(input logic [8:0] m, input int n);
      repeat (n)
      begin
         @(posedge clk);
         ev <= m;
      end
      @(posedge clk);
      ev <= 9'h000;
   endtask
   task automatic tick_second();
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
   endtask
   // hang guard: saturation run dominates, about 66k cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         err_count++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      foreach (ad[i])
      begin
         host.rd(ad[i], v);
         check("reset value", v, 8'h00);
      end
      for (int i = 0; i < 8; i++)
      begin
         host.wr(8'h6E, 8'h01 << i);
         host.wr(8'h6F, 8'h01 << i);
         host.rd(8'h6E, v);
         check("first mask", v, 8'h01 << i);
         host.rd(8'h6F, v);
         check("second mask", v, (8'h01 << i) & 8'hFE);
         stf <= ~(8'h01 << i);
         sts <= 8'h01 << i;
         @(posedge clk);
         check("int_b", int_b, (i == 0) ? 8'h01 : 8'h00);
         stf <= 8'h01 << i;
         sts <= ~(8'h01 << i);
         @(posedge clk);
         check("int_b", int_b, 8'h00);
      end
      host.wr(8'h24, 8'hFF);
      foreach (cs[i])
      begin
         {cfg, lost} <= cs[i][17:12];
         tick_second();
         fire(cs[i][11:3], 3);
         tick_second();
         host.rd(8'h24, v);
         check("line count", v, cs[i][2] ? 8'h03 : 8'h00);
         host.rd(8'h26, v);
         check("path count", v, cs[i][1] ? 8'h03 : 8'h00);
         host.rd(8'h27, v);
         check("sync count", v, cs[i][0] ? 8'h03 : 8'h00);
      end
      // 256 out-of-sync multiframes reach the high nibble while the path
      // count stays zero, so a swapped nibble order in the shared byte shows
      {cfg, lost} <= {5'b00001, 1'b0};
      tick_second();
      fire(9'h001, 256);
      tick_second();
      host.rd(8'h25, v);
      check("shared high byte", v, 8'h10);
      host.rd(8'h27, v);
      check("sync low byte", v, 8'h00);
      {cfg, lost} <= 6'h00;
      tick_second();
      fire(9'h108, 65540);
      tick_second();
      for (int i = 0; i < 5; i++)
      begin
         host.rd(ad[i], v);
         check("saturated byte", v, 8'hFF);
      end
      tick_second();
      host.rd(8'h24, v);
      check("empty second", v, 8'h00);
      tally_and_finish();
   end
endmodule
`default_nettype wire
